/* File: pkg/rtc_pkg.sv */
// rtc package: command codes, register layout, reset values, trim and divider constants
// assumes every user writes rtc_pkg::name, nothing is imported
package rtc_pkg;

    // ------------------------------------------------------------
    // command byte: prefix, register code, direction flag last
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_PREFIX   = 4'h6;
    localparam logic [2:0] CODE_STATUS1 = 3'h0;
    localparam logic [2:0] CODE_STATUS2 = 3'h1;
    localparam logic [2:0] CODE_INT1    = 3'h4;
    localparam logic [2:0] CODE_INT2    = 3'h5;
    localparam logic [2:0] CODE_TRIM    = 3'h6;
    localparam logic [2:0] CODE_FREE    = 3'h7;
    localparam logic [5:0] CNT_CMD_LAST = 6'h07;
    localparam logic [5:0] CNT_MAX      = 6'h3F;
    localparam logic [2:0] LEN_ONE      = 3'h1;
    localparam logic [2:0] LEN_ALARM    = 3'h3;
    localparam logic [2:0] LEN_NONE     = 3'h0;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         ST2_ALARM1_BIT       = 5;
    localparam int         ST2_FREQ_BIT         = 4;
    localparam int         ST2_ALARM2_EN_BIT    = 1;
    localparam int         TRIM_STEP_SELECT_BIT = 0;
    localparam logic [7:0] ST2_RESET            = 8'h00;
    localparam logic [7:0] INT_RESET            = 8'h00;
    localparam logic [7:0] TRIM_RESET           = 8'h00;
    localparam logic [7:0] FREE_RESET           = 8'h00;
    localparam logic       PWR_FLAG_RESET       = 1'b1;

    // ------------------------------------------------------------
    // trim: step in parts per billion, correction period in seconds
    // ------------------------------------------------------------
    localparam longint OSC_HZ                = 32768;
    localparam longint PPB_SCALE             = 1000000000;
    localparam longint TRIM_STEP_COARSE_PPB  = 3052;
    localparam longint TRIM_STEP_FINE_PPB    = 1017;
    localparam longint TRIM_PERIOD_COARSE_S  = 20;
    localparam longint TRIM_PERIOD_FINE_S    = 60;
    localparam int     TRIM_TICKS_COARSE     = int'((TRIM_PERIOD_COARSE_S * TRIM_STEP_COARSE_PPB
                                                 * OSC_HZ + PPB_SCALE / 2) / PPB_SCALE);
    localparam int     TRIM_TICKS_FINE       = int'((TRIM_PERIOD_FINE_S * TRIM_STEP_FINE_PPB
                                                 * OSC_HZ + PPB_SCALE / 2) / PPB_SCALE);
    localparam logic [5:0]  SEC_LAST_COARSE  = 6'(TRIM_PERIOD_COARSE_S - 1);
    localparam logic [5:0]  SEC_LAST_FINE    = 6'(TRIM_PERIOD_FINE_S - 1);
    localparam logic [16:0] SEC_TICKS        = 17'(OSC_HZ);
    localparam logic [16:0] HALF_TICKS       = 17'(OSC_HZ / 2);

    typedef enum logic [3:0] {
        LINK_CMD = 4'b0001,
        LINK_RD  = 4'b0010,
        LINK_WR  = 4'b0100,
        LINK_IGN = 4'b1000
    } rtc_link_state_t;

endpackage

/* File: verilog/rtc_sync.sv */
// rtc_sync: two flip-flop level synchroniser, one chain per bit
// assumes d_in bits change slowly or as toggles; reset is asynchronous active low
`timescale 1ns/1ps

module rtc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule // rtc_sync

/* File: verilog/rtc_trim_div.sv */
// rtc_trim_div: 1 Hz divider from oscillator ticks with periodic rate trim
// assumes tick_in is a one-cycle pulse per oscillator period, trim_in is quasi static
`timescale 1ns/1ps

module rtc_trim_div (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        tick_in,
    input  wire logic [7:0]  trim_in,
    output logic             one_hz_out,
    output logic [7:0]       taps_out
);

    // bits 7..1 reversed, bit 1 is the sign
    function automatic logic signed [6:0] trim_count(input logic [7:0] t);
        logic signed [6:0] c;
        c = '0;
        for (int i = 0; i < 7; i++) begin
            c[6 - i] = t[i + 1];
        end
        return c;
    endfunction

    logic              fine_w;
    logic signed [6:0] count_w;
    logic signed [17:0] step_w;
    logic signed [17:0] len_w;
    logic [16:0]       cur_len_w;
    logic [16:0]       div_q;
    logic [5:0]        sec_q;
    logic [5:0]        sec_last_w;

    // ------------------------------------------------------------
    // second length
    // ------------------------------------------------------------
    always_comb begin
        fine_w     = trim_in[rtc_pkg::TRIM_STEP_SELECT_BIT];
        count_w    = trim_count(trim_in);
        step_w     = 18'(count_w) * 18'(fine_w ? rtc_pkg::TRIM_TICKS_FINE
                                               : rtc_pkg::TRIM_TICKS_COARSE);
        len_w      = $signed({1'b0, rtc_pkg::SEC_TICKS}) - step_w;
        sec_last_w = fine_w ? rtc_pkg::SEC_LAST_FINE : rtc_pkg::SEC_LAST_COARSE;
        // only the first second of each period is stretched or shortened
        cur_len_w  = (sec_q == 6'h00 && count_w != 7'sd0) ? 17'(len_w)
                                                          : rtc_pkg::SEC_TICKS;
    end

    // ------------------------------------------------------------
    // divider chain, the oscillator itself is never touched
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_q <= 17'h00000;
            sec_q <= 6'h00;
        end else if (tick_in) begin
            if (div_q >= 17'(cur_len_w - 17'h00001)) begin
                div_q <= 17'h00000;
                sec_q <= (sec_q >= sec_last_w) ? 6'h00 : 6'(sec_q + 6'h01);
            end else begin
                div_q <= 17'(div_q + 17'h00001);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            // matches div_q == 0, so the pin shows no false low pulse after reset
            one_hz_out <= 1'b1;
            taps_out   <= 8'h00;
        end else begin
            one_hz_out <= div_q < rtc_pkg::HALF_TICKS;
            taps_out   <= div_q[14:7];
        end
    end

    a_trim_second_len: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (sec_q != 6'h00) |-> (cur_len_w == rtc_pkg::SEC_TICKS))
        else $error("untrimmed second has wrong length");

    a_divider_wrap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (tick_in && div_q == 17'(cur_len_w - 17'h00001)) |=> (div_q == 17'h00000))
        else $error("divider did not wrap at second end");

endmodule // rtc_trim_div

/* File: verilog/rtc_serial_trim.sv */
// rtc_serial_trim: three-wire host link, register storage, interrupt pin and trim divider
// assumes sck_in, cs_in, sio_in, osc_32k_in arrive from pins; mclk_in is the system clock
`timescale 1ns/1ps

module rtc_serial_trim (
    input  wire logic mclk_in,
    input  wire logic rst_b_in,
    input  wire logic osc_32k_in,
    input  wire logic sck_in,
    input  wire logic cs_in,
    input  wire logic sio_in,
    output logic      sio_out,
    output logic      sio_oe_out,
    output logic      int_b_out,
    output logic      clk32_out
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // link domain: frame state
    // ------------------------------------------------------------
    logic                     link_rst_n;
    logic [5:0]               bit_cnt_q;
    logic [7:0]               cmd_q;
    logic [6:0]               shift_q;
    rtc_pkg::rtc_link_state_t state_q;
    logic [2:0]               cmd_code;
    logic [2:0]               byte_idx;
    logic [7:0]               wr_byte;
    logic                     wr_done;
    logic [7:0]               rd_byte_w;
    logic                     pwr_flag_link;

    logic [7:0] st2_q;
    logic [7:0] int1_q [0:2];
    logic [7:0] int2_q [0:2];
    logic [7:0] trim_q;
    logic [7:0] free_q;
    logic       st1_tgl_q;
    logic       cfg_tgl_q;
    logic       pwr_flag_q;

    // select low clears the frame without touching stored registers
    assign link_rst_n = cs_in & rst_n_q;
    assign cmd_code   = cmd_q[3:1];
    assign byte_idx   = 3'(bit_cnt_q[5:3] - 3'h1);
    assign wr_byte    = {shift_q, sio_in};

    function automatic logic [2:0] reg_len(input logic [2:0] code, input logic [7:0] st2);
        case (code)
            rtc_pkg::CODE_STATUS1,
            rtc_pkg::CODE_STATUS2,
            rtc_pkg::CODE_TRIM,
            rtc_pkg::CODE_FREE: reg_len = rtc_pkg::LEN_ONE;
            rtc_pkg::CODE_INT1: reg_len = st2[rtc_pkg::ST2_ALARM1_BIT] ? rtc_pkg::LEN_ALARM
                                                                      : rtc_pkg::LEN_ONE;
            rtc_pkg::CODE_INT2: reg_len = st2[rtc_pkg::ST2_ALARM2_EN_BIT] ? rtc_pkg::LEN_ALARM
                                                                         : rtc_pkg::LEN_ONE;
            default:            reg_len = rtc_pkg::LEN_NONE;
        endcase
    endfunction

    // length is taken from the live status two, so it must be set first
    assign wr_done = state_q == rtc_pkg::LINK_WR && bit_cnt_q[2:0] == 3'h7
                     && byte_idx < reg_len(cmd_code, st2_q);

    always_ff @(posedge sck_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= 6'h00;
        end else if (bit_cnt_q != rtc_pkg::CNT_MAX) begin
            bit_cnt_q <= 6'(bit_cnt_q + 6'h01);
        end
    end

    always_ff @(posedge sck_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cmd_q   <= 8'h00;
            shift_q <= 7'h00;
        end else begin
            if (bit_cnt_q <= rtc_pkg::CNT_CMD_LAST) begin
                cmd_q <= {cmd_q[6:0], sio_in};
            end
            shift_q <= wr_byte[6:0];
        end
    end

    always_ff @(posedge sck_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_q <= rtc_pkg::LINK_CMD;
        end else begin
            unique case (state_q)
                rtc_pkg::LINK_CMD: begin
                    // nothing happens before the eighth edge
                    if (bit_cnt_q == rtc_pkg::CNT_CMD_LAST) begin
                        if (cmd_q[6:3] != rtc_pkg::CMD_PREFIX) begin
                            state_q <= rtc_pkg::LINK_IGN;
                        end else if (sio_in) begin
                            state_q <= rtc_pkg::LINK_RD;
                        end else begin
                            state_q <= rtc_pkg::LINK_WR;
                        end
                    end
                end
                rtc_pkg::LINK_RD,
                rtc_pkg::LINK_WR,
                rtc_pkg::LINK_IGN: state_q <= state_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // link domain: register storage, kept across frames
    // ------------------------------------------------------------
    always_ff @(posedge sck_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st2_q  <= rtc_pkg::ST2_RESET;
            trim_q <= rtc_pkg::TRIM_RESET;
            free_q <= rtc_pkg::FREE_RESET;
            for (int i = 0; i < 3; i++) begin
                int1_q[i] <= rtc_pkg::INT_RESET;
                int2_q[i] <= rtc_pkg::INT_RESET;
            end
        end else if (wr_done) begin
            case (cmd_code)
                rtc_pkg::CODE_STATUS2: st2_q <= wr_byte;
                rtc_pkg::CODE_INT1:    int1_q[byte_idx[1:0]] <= wr_byte;
                rtc_pkg::CODE_INT2:    int2_q[byte_idx[1:0]] <= wr_byte;
                rtc_pkg::CODE_TRIM:    trim_q <= wr_byte;
                rtc_pkg::CODE_FREE:    free_q <= wr_byte;
                default: ;
            endcase
        end
    end

    // toggles tell the system side that a write landed
    always_ff @(posedge sck_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st1_tgl_q <= 1'b0;
            cfg_tgl_q <= 1'b0;
        end else if (wr_done) begin
            if (cmd_code == rtc_pkg::CODE_STATUS1) begin
                st1_tgl_q <= ~st1_tgl_q;
            end else begin
                cfg_tgl_q <= ~cfg_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: read path, driven on the falling edge
    // ------------------------------------------------------------
    always_comb begin
        rd_byte_w = 8'h00;
        case (cmd_code)
            rtc_pkg::CODE_STATUS1: rd_byte_w = {7'h00, pwr_flag_link};
            rtc_pkg::CODE_STATUS2: rd_byte_w = st2_q;
            rtc_pkg::CODE_INT1:    rd_byte_w = (byte_idx < 3'h3) ? int1_q[byte_idx[1:0]] : 8'h00;
            rtc_pkg::CODE_INT2:    rd_byte_w = (byte_idx < 3'h3) ? int2_q[byte_idx[1:0]] : 8'h00;
            rtc_pkg::CODE_TRIM:    rd_byte_w = trim_q;
            rtc_pkg::CODE_FREE:    rd_byte_w = free_q;
            default:               rd_byte_w = 8'h00;
        endcase
    end

    always_ff @(negedge sck_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sio_oe_out <= 1'b0;
            sio_out    <= 1'b0;
        end else if (state_q == rtc_pkg::LINK_RD && byte_idx < reg_len(cmd_code, st2_q)) begin
            sio_oe_out <= 1'b1;
            sio_out    <= rd_byte_w[~bit_cnt_q[2:0]];
        end else begin
            sio_oe_out <= 1'b0;
        end
    end

    // power flag into the link domain; settles during the command byte
    rtc_sync #(
        .WIDTH (1)
    ) u_pwr_sync (
        .clk_in   (sck_in),
        .rst_b_in (rst_n_q),
        .d_in     (pwr_flag_q),
        .q_out    (pwr_flag_link)
    );

    // ------------------------------------------------------------
    // system domain: crossings, power flag, interrupt pin
    // ------------------------------------------------------------
    logic [2:0] sync_w;
    logic [2:0] sync_d_q;
    logic       osc_tick;
    logic [7:0] cfg_st2_q;
    logic [7:0] cfg_trim_q;
    logic [7:0] cfg_int1_q;
    logic       one_hz;
    logic [7:0] taps;

    rtc_sync #(
        .WIDTH (3)
    ) u_sys_sync (
        .clk_in   (mclk_in),
        .rst_b_in (rst_n_q),
        .d_in     ({osc_32k_in, st1_tgl_q, cfg_tgl_q}),
        .q_out    (sync_w)
    );

    assign osc_tick = sync_w[2] & ~sync_d_q[2];

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sync_d_q  <= 3'h0;
            clk32_out <= 1'b0;
        end else begin
            sync_d_q  <= sync_w;
            clk32_out <= sync_w[2];
        end
    end

    // link registers are stable for a whole byte after the toggle flips
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cfg_st2_q  <= rtc_pkg::ST2_RESET;
            cfg_trim_q <= rtc_pkg::TRIM_RESET;
            cfg_int1_q <= rtc_pkg::INT_RESET;
        end else if (sync_w[0] != sync_d_q[0]) begin
            cfg_st2_q  <= st2_q;
            cfg_trim_q <= trim_q;
            cfg_int1_q <= int1_q[0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pwr_flag_q <= rtc_pkg::PWR_FLAG_RESET;
        end else if (sync_w[1] != sync_d_q[1]) begin
            pwr_flag_q <= 1'b0;
        end
    end

    rtc_trim_div u_div (
        .clk_in     (mclk_in),
        .rst_b_in   (rst_n_q),
        .tick_in    (osc_tick),
        .trim_in    (cfg_trim_q),
        .one_hz_out (one_hz),
        .taps_out   (taps)
    );

    // selected taps are and-ed; alarm compare is not part of this block
    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            int_b_out <= 1'b1;
        end else if (pwr_flag_q) begin
            int_b_out <= one_hz;
        end else if (cfg_st2_q[rtc_pkg::ST2_FREQ_BIT] && cfg_int1_q != 8'h00) begin
            int_b_out <= ~&(taps | ~cfg_int1_q);
        end else begin
            int_b_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_cmd_ok;
        bit_cnt_q == rtc_pkg::CNT_CMD_LAST && cmd_q[6:3] == rtc_pkg::CMD_PREFIX;
    endsequence

    a_clock_wait: assert property (@(posedge sck_in) disable iff (!link_rst_n)
        (bit_cnt_q < rtc_pkg::CNT_CMD_LAST) |=> (state_q == rtc_pkg::LINK_CMD && !wr_done))
        else $error("left command wait too early");

    a_dir_read: assert property (@(posedge sck_in) disable iff (!link_rst_n)
        (s_cmd_ok and sio_in) |=> (state_q == rtc_pkg::LINK_RD))
        else $error("read flag not honoured");

    a_dir_write: assert property (@(posedge sck_in) disable iff (!link_rst_n)
        (s_cmd_ok and !sio_in) |=> (state_q == rtc_pkg::LINK_WR))
        else $error("write flag not honoured");

    a_read_bit_out: assert property (@(posedge sck_in) disable iff (!link_rst_n)
        (state_q == rtc_pkg::LINK_RD && byte_idx < reg_len(cmd_code, st2_q))
        |-> (sio_oe_out && sio_out == rd_byte_w[~bit_cnt_q[2:0]]))
        else $error("read bit not driven");

    a_status_select: assert property (@(posedge sck_in) disable iff (!rst_n_q)
        (wr_done && cmd_code == rtc_pkg::CODE_STATUS2) |=> (st2_q == $past(wr_byte)))
        else $error("status two not written");

    a_int_select: assert property (@(posedge sck_in) disable iff (!rst_n_q)
        (wr_done && cmd_code == rtc_pkg::CODE_INT2 && byte_idx == 3'h0)
        |=> (int2_q[0] == $past(wr_byte) && $stable(int1_q[0])))
        else $error("interrupt selector wrong");

    a_int1_length: assert property (@(posedge sck_in) disable iff (!link_rst_n)
        (state_q == rtc_pkg::LINK_RD && cmd_code == rtc_pkg::CODE_INT1 && bit_cnt_q == 6'h10)
        |-> (sio_oe_out == st2_q[rtc_pkg::ST2_ALARM1_BIT]))
        else $error("interrupt one length wrong");

    a_int2_length: assert property (@(posedge sck_in) disable iff (!link_rst_n)
        (state_q == rtc_pkg::LINK_RD && cmd_code == rtc_pkg::CODE_INT2 && bit_cnt_q == 6'h10)
        |-> (sio_oe_out == st2_q[rtc_pkg::ST2_ALARM2_EN_BIT]))
        else $error("interrupt two length wrong");

    a_select_release: assert property (@(posedge mclk_in) disable iff (!rst_n_q)
        !cs_in |-> !sio_oe_out)
        else $error("data driven while deselected");

    a_power_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_q)
        pwr_flag_q |=> (int_b_out == $past(one_hz)))
        else $error("power-up pulse train missing");

    a_osc_passthru: assert property (@(posedge mclk_in) disable iff (!rst_n_q)
        1'b1 |=> (clk32_out == $past(sync_w[2])))
        else $error("oscillator output disturbed");

endmodule // rtc_serial_trim

/* File: verification/rtc_host_model.sv */
// host model: select, inverted shift clock and data line of the link
// assumes the bench feeds line_out to the device data input
`timescale 1ns/1ps

module rtc_host_model (
    input  wire logic so_in,
    input  wire logic oe_in,
    output logic      sck_out,
    output logic      cs_out,
    output logic      line_out
);
    logic hd, ho, fl;
    // a released line toggles so a stale bit never reads as good data
    assign line_out = oe_in ? so_in : (ho ? hd : fl);
    initial {sck_out, cs_out, hd, ho, fl} = 5'h10;
    task automatic xfer(input logic [31:0] w, input int n, output logic [23:0] r);
        r = 24'h0;
        cs_out = 1'b1;
        #45;
        for (int i = 0; i < n; i++) begin
            sck_out = 1'b0;
            fl = ~fl;
            ho = (i < 8) || !w[24];
            hd = w[31-i];
            #15;
            sck_out = 1'b1;
            if (i > 7) r = {r[22:0], line_out};
            #15;
        end
        #30;
        ho = 1'b0;
        cs_out = 1'b0;
        #60;
    endtask
endmodule // rtc_host_model

/* File: verification/rtc_serial_trim_tb_top.sv */
// bench: serial link, register store, interrupt pin, oscillator copy
// assumes rtc_host_model as link master; oscillator sped up to 160 ns
`timescale 1ns/1ps

module rtc_serial_trim_tb_top;
    logic        clk, rst_b, osc, sck, cs, line, so, oe, int_b, c32, seen;
    logic [1:0]  oc;
    logic [23:0] v;
    logic [10:0] rows [5];
    int          mismatches, checks, r, f;
    rtc_serial_trim uut (.mclk_in(clk), .rst_b_in(rst_b), .osc_32k_in(osc), .sck_in(sck),
        .cs_in(cs), .sio_in(line), .sio_out(so), .sio_oe_out(oe), .int_b_out(int_b),
        .clk32_out(c32));
    rtc_host_model host (.so_in(so), .oe_in(oe), .sck_out(sck), .cs_out(cs), .line_out(line));
    always #20 clk = ~clk;
    always @(negedge clk) begin
        oc <= oc + 2'h1;
        osc <= oc[1];
    end
    always @(posedge oe) seen = 1'b1;
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [2:0] c, input int n, input logic [23:0] d);
        host.xfer({rtc_pkg::CMD_PREFIX, c, 1'b0, d}, n, v);
    endtask
    task automatic rd(input logic [2:0] c, input int n);
        host.xfer({rtc_pkg::CMD_PREFIX, c, 1'b1, 24'h0}, n, v);
    endtask
    task automatic edges(input int n);
        logic p, q;
        r = 0;
        f = 0;
        repeat (n) begin
            p = c32;
            q = int_b;
            @(negedge clk);
            r += int'(c32 && !p);
            f += int'(q && !int_b);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        wrap_up();
    end
    initial begin
        {clk, rst_b, osc, oc, seen, mismatches, checks} = '0;
        rows = '{{rtc_pkg::CODE_STATUS2, 8'h0C}, {rtc_pkg::CODE_INT1, 8'h5A},
            {rtc_pkg::CODE_INT2, 8'hA5}, {rtc_pkg::CODE_TRIM, 8'h66},
            {rtc_pkg::CODE_FREE, 8'hC3}};
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        chk(int_b, 24'h1);
        @(negedge clk);
        chk(int_b, 24'h1);
        rd(rtc_pkg::CODE_STATUS1, 16);
        chk(v, 24'h1);
        rd(rtc_pkg::CODE_TRIM, 16);
        chk(v, 24'(rtc_pkg::TRIM_RESET));
        foreach (rows[i]) begin
            wr(rows[i][10:8], 16, {rows[i][7:0], 16'h0});
            rd(rows[i][10:8], 16);
            chk(v, 24'(rows[i][7:0]));
        end
        wr(rtc_pkg::CODE_TRIM, 5, 24'hFF0000);
        rd(rtc_pkg::CODE_TRIM, 12);
        chk(oe, 24'h0);
        rd(rtc_pkg::CODE_TRIM, 16);
        chk(v, 24'h66);
        seen = 1'b0;
        rd(3'h2, 16);
        chk(seen, 24'h0);
        wr(rtc_pkg::CODE_STATUS1, 16, 24'h0);
        rd(rtc_pkg::CODE_STATUS1, 16);
        chk(v, 24'h0);
        wr(rtc_pkg::CODE_STATUS2, 16, 24'h220000);
        wr(rtc_pkg::CODE_INT1, 32, 24'h123456);
        wr(rtc_pkg::CODE_INT2, 32, 24'hABCDEF);
        rd(rtc_pkg::CODE_INT1, 32);
        chk(v, 24'h123456);
        rd(rtc_pkg::CODE_INT2, 32);
        chk(v, 24'hABCDEF);
        wr(rtc_pkg::CODE_TRIM, 16, 24'h0);
        wr(rtc_pkg::CODE_STATUS2, 16, 24'h100000);
        wr(rtc_pkg::CODE_INT2, 16, 24'h010000);
        wr(rtc_pkg::CODE_INT1, 16, 24'h0);
        repeat (16) @(negedge clk);
        edges(2048);
        chk(24'(f), 24'h0);
        chk(24'(r), 24'h200);
        wr(rtc_pkg::CODE_INT1, 16, 24'h010000);
        repeat (16) @(negedge clk);
        edges(2048);
        chk(24'(f), 24'h2);
        wrap_up();
    end
endmodule // rtc_serial_trim_tb_top
